// file: iee_host.sv
// Two-wire bus master that drives the EEPROM engine from a register port.
// Assumes one-cycle strobes on the register port; SDA returns asynchronously.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module iee_host
  import iee_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  iee_if.host              BUS,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [15:0] REG_RDATA_OUT
);
  // ==========================================================
  // Declarations
  iee_hstate_t state_ff;
  iee_cmd_t    cmd_ff;
  logic [15:0] addr_ff;
  logic [7:0]  wdata_ff;
  logic [7:0]  rdata_ff;
  logic [2:0]  sel_ff;
  logic [4:0]  step_ff;
  logic [3:0]  bit_ff;
  logic [1:0]  ph_ff;
  logic [7:0]  q_ff;
  logic        nack_ff;
  logic        unk_ff;
  logic        abort_ff;
  logic        scl_ff;
  logic        oe_n_ff;
  logic [1:0]  sda_ff;
  iee_item_t   item;
  iee_kind_t   kind;
  logic        go;
  logic        sda_val;

  // ==========================================================
  // Command programs
  function automatic iee_item_t prog_item(input iee_cmd_t c, input logic [4:0] s,
                                          input logic [15:0] a, input logic [7:0] d,
                                          input logic [2:0] sel);
    logic [7:0] dw;
    logic [7:0] dr;
    iee_kind_t  hk;
    iee_item_t  it;
    dw = {IEE_DEV_CODE, IEE_SMALL ? a[10:8] : sel, 1'b0};
    dr = dw | 8'h01;
    hk = IEE_SMALL ? IT_SKIP : IT_TXB;
    it = '{IT_END, 8'h00};
    case (c)
      IEE_C_WRITE: begin
        case (s)
          5'h0: it = '{IT_START, 8'h00};
          5'h1: it = '{IT_TXB, dw};
          5'h2: it = '{hk, a[15:8]};
          5'h3: it = '{IT_TXB, a[7:0]};
          5'h4: it = '{IT_TXB, d};
          5'h5: it = '{IT_STOP, 8'h00};
          default: it = '{IT_END, 8'h00};
        endcase
      end
      IEE_C_RREAD: begin
        case (s)
          5'h0: it = '{IT_START, 8'h00};
          5'h1: it = '{IT_TXB, dw};
          5'h2: it = '{hk, a[15:8]};
          5'h3: it = '{IT_TXB, a[7:0]};
          5'h4: it = '{IT_START, 8'h00};
          5'h5: it = '{IT_TXB, dr};
          5'h6: it = '{IT_RXB, 8'h00};
          5'h7: it = '{IT_STOP, 8'h00};
          default: it = '{IT_END, 8'h00};
        endcase
      end
      IEE_C_CREAD: begin
        case (s)
          5'h0: it = '{IT_START, 8'h00};
          5'h1: it = '{IT_TXB, dr};
          5'h2: it = '{IT_RXB, 8'h00};
          5'h3: it = '{IT_STOP, 8'h00};
          default: it = '{IT_END, 8'h00};
        endcase
      end
      IEE_C_POLL: begin
        case (s)
          5'h0: it = '{IT_START, 8'h00};
          5'h1: it = '{IT_TXB, dw};
          5'h2: it = '{IT_STOP, 8'h00};
          default: it = '{IT_END, 8'h00};
        endcase
      end
      IEE_C_SRST: begin
        if (s < 5'(IEE_SRST_CLKS)) begin
          it = '{IT_DUM, 8'h00};
        end else if (s < 5'(IEE_SRST_CLKS + 2)) begin
          it = '{IT_START, 8'h00};
        end else if (s == 5'(IEE_SRST_CLKS + 2)) begin
          it = '{IT_STOP, 8'h00};
        end
      end
      IEE_C_CANCEL: begin
        case (s)
          5'h0: it = '{IT_START, 8'h00};
          5'h1: it = '{IT_STOP, 8'h00};
          default: it = '{IT_END, 8'h00};
        endcase
      end
      default: it = '{IT_END, 8'h00};
    endcase
    return it;
  endfunction

  assign item    = prog_item(cmd_ff, step_ff, addr_ff, wdata_ff, sel_ff);
  assign kind    = abort_ff ? IT_STOP : item.kind;
  assign go      = REG_WR_IN && (REG_ADDR_IN == IEE_REG_CMD) && (state_ff == S_IDLE);
  assign sda_val = (kind == IT_STOP) ? 1'b0 :
                   ((kind == IT_TXB) && (bit_ff != 4'h8)) ? item.val[3'(4'h7 - bit_ff)] :
                   1'b1;

  // ==========================================================
  // Register port
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
      sel_ff   <= IEE_SEL_RST;
    end else if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        IEE_REG_ADDR: addr_ff <= REG_WDATA_IN;
        IEE_REG_DATA: wdata_ff <= REG_WDATA_IN[7:0];
        IEE_REG_SEL:  sel_ff <= REG_WDATA_IN[2:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_RDATA_OUT <= 16'h0000;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        IEE_REG_CMD:  REG_RDATA_OUT <= {13'h0000, cmd_ff};
        IEE_REG_ADDR: REG_RDATA_OUT <= addr_ff;
        IEE_REG_DATA: REG_RDATA_OUT <= {8'h00, rdata_ff};
        IEE_REG_STAT: REG_RDATA_OUT <= {13'h0000, unk_ff, nack_ff, state_ff == S_RUN};
        IEE_REG_SEL:  REG_RDATA_OUT <= {13'h0000, sel_ff};
        default:      REG_RDATA_OUT <= 16'h0000;
      endcase
    end else begin
      REG_RDATA_OUT <= 16'h0000;
    end
  end

  // ==========================================================
  // Bit engine: four quarter-phases per SCL period
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sda_ff <= 2'h3;
    end else begin
      sda_ff <= {sda_ff[0], BUS.sda};
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_ff <= S_IDLE;
      cmd_ff   <= IEE_C_WRITE;
      step_ff  <= 5'h00;
      bit_ff   <= 4'h0;
      ph_ff    <= 2'h0;
      q_ff     <= 8'h00;
      nack_ff  <= 1'b0;
      unk_ff   <= 1'b1;
      abort_ff <= 1'b0;
      rdata_ff <= 8'h00;
      scl_ff   <= 1'b1;
      oe_n_ff  <= 1'b1;
    end else if (state_ff == S_IDLE) begin
      if (go) begin
        if ((REG_WDATA_IN[2:0] == IEE_C_CREAD) && unk_ff) begin
          cmd_ff <= IEE_C_RREAD;
        end else begin
          cmd_ff <= iee_cmd_t'(REG_WDATA_IN[2:0]);
        end
        if (REG_WDATA_IN[2:0] == IEE_C_CANCEL) begin
          unk_ff <= 1'b1;
        end else if (REG_WDATA_IN[2:0] inside {IEE_C_WRITE, IEE_C_RREAD, IEE_C_CREAD}) begin
          unk_ff <= 1'b0;
        end
        state_ff <= S_RUN;
        step_ff  <= 5'h00;
        bit_ff   <= 4'h0;
        ph_ff    <= 2'h0;
        q_ff     <= 8'h00;
        nack_ff  <= 1'b0;
        abort_ff <= 1'b0;
      end
    end else if (kind == IT_END) begin
      state_ff <= S_IDLE;
    end else if (kind == IT_SKIP) begin
      step_ff <= step_ff + 5'h01;
    end else if (q_ff != 8'(IEE_SCLQ_CYC - 1)) begin
      q_ff <= q_ff + 8'h01;
    end else begin
      q_ff  <= 8'h00;
      ph_ff <= ph_ff + 2'h1;
      case (ph_ff)
        2'h0: begin
          scl_ff  <= 1'b0;
          oe_n_ff <= sda_val;
        end
        2'h1: scl_ff <= 1'b1;
        2'h2: begin
          if (kind == IT_START) begin
            oe_n_ff <= 1'b0;
          end else if (kind == IT_STOP) begin
            oe_n_ff <= 1'b1;
          end else if ((kind == IT_TXB) && (bit_ff == 4'h8) && sda_ff[1]) begin
            nack_ff  <= 1'b1;
            abort_ff <= 1'b1;
          end else if ((kind == IT_RXB) && (bit_ff != 4'h8)) begin
            rdata_ff <= {rdata_ff[6:0], sda_ff[1]};
          end
        end
        default: begin
          if (((kind == IT_TXB) || (kind == IT_RXB)) && (bit_ff != 4'h8)) begin
            bit_ff <= bit_ff + 4'h1;
          end else if ((kind == IT_STOP) && abort_ff && (bit_ff == 4'h0)) begin
            state_ff <= S_IDLE;
          end else begin
            bit_ff  <= 4'h0;
            step_ff <= step_ff + 5'h01;
          end
        end
      endcase
    end
  end

  assign BUS.scl           = scl_ff;
  assign BUS.host_sda_oe_n = oe_n_ff;
  assign BUS.host_sda_out  = 1'b0;
endmodule

// file: iee_pkg.sv
// Shared constants and types of the two-wire EEPROM engine and its master.
// Assumes a 100 MHz system clock on both ends.
package iee_pkg;
  // ==========================================================
  // Geometry
  localparam logic IEE_SMALL   = 1'b0;
  localparam int   IEE_ADDR_W  = IEE_SMALL ? 11 : 12;
  localparam int   IEE_PB      = IEE_SMALL ? 4 : 5;
  localparam int   IEE_PAGE_N  = 1 << IEE_PB;
  localparam int   IEE_MEM_N   = 1 << IEE_ADDR_W;
  localparam logic [3:0] IEE_DEV_CODE = 4'hA;
  // ==========================================================
  // Timing
  localparam int IEE_CLK_NS    = 10;
  localparam int IEE_T_WR_NS   = 5000000;
  localparam int IEE_WR_CYC    = IEE_T_WR_NS / IEE_CLK_NS;
  localparam int IEE_T_SCLQ_NS = 625;
  localparam int IEE_SCLQ_CYC  = (IEE_T_SCLQ_NS + IEE_CLK_NS - 1) / IEE_CLK_NS;
  localparam int IEE_SRST_CLKS = 14;
  // ==========================================================
  // Master register map
  localparam logic [7:0] IEE_REG_CMD  = 8'h00;
  localparam logic [7:0] IEE_REG_ADDR = 8'h04;
  localparam logic [7:0] IEE_REG_DATA = 8'h08;
  localparam logic [7:0] IEE_REG_STAT = 8'h0C;
  localparam logic [7:0] IEE_REG_SEL  = 8'h10;
  localparam int IEE_STAT_BUSY = 0;
  localparam int IEE_STAT_NACK = 1;
  localparam int IEE_STAT_UNK  = 2;
  localparam logic [2:0] IEE_SEL_RST = 3'h0;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    IEE_C_WRITE = 3'h0, IEE_C_RREAD = 3'h1, IEE_C_CREAD = 3'h2,
    IEE_C_POLL = 3'h3, IEE_C_SRST = 3'h4, IEE_C_CANCEL = 3'h5
  } iee_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_DEVSEL = 3'h1, ST_WA_HI = 3'h3, ST_WA_LO = 3'h2,
    ST_WDATA = 3'h6, ST_RDATA = 3'h7, ST_WAIT = 3'h5, ST_BUSY = 3'h4
  } iee_dstate_t;
  typedef enum logic {S_IDLE = 1'b0, S_RUN = 1'b1} iee_hstate_t;
  typedef enum logic [2:0] {
    IT_START = 3'h0, IT_STOP = 3'h1, IT_TXB = 3'h2, IT_RXB = 3'h3,
    IT_DUM = 3'h4, IT_SKIP = 3'h5, IT_END = 3'h6
  } iee_kind_t;
  typedef struct packed {
    iee_kind_t  kind;
    logic [7:0] val;
  } iee_item_t;
endpackage

// file: iee_if.sv
// Two-wire link between the EEPROM engine and its master.
// SDA is open drain: each end only pulls low; released means pulled up.
`timescale 1ns/1ps
interface iee_if;
  logic scl;
  logic sda;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  // Wired-AND with pull-up
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_out, output host_sda_oe_n);
endinterface

// file: iee_dev.sv
// Two-wire serial EEPROM slave: command engine, page buffer and array.
// Assumes SCL/SDA/WP/straps are asynchronous pins; SYS_CLK_IN >> SCL rate.
//
// What this block does
// - Program only on stop after whole byte
// - Refuse commands during internal write time
// - Page write takes up to page bytes
// - Surplus bytes wrap, overwriting first ones
// - Small parts: page from slave address bits
// - Middle parts: 5-bit in-page increment
// - Full page takes one write time
// - Write protect high refuses all writes
// - Protect high during write aborts it
// - Protect ignored until first data byte
// - Abort returns straight to standby
// - Random read returns addressed byte
// - Current read uses internal address
// - Low acknowledge: next byte follows
// - Master ends reads with high acknowledge
// - Three soft-reset sequences return to idle
// - Master releases SDA on dummy clocks
// - Busy: no acknowledge, master polls
// - Start then stop cancels command
// - Master soft-resets only on IEE_C_SRST command
// - After cancel, next read is random
// - Address LSB selects read or write
// - Acknowledge address and received bytes
`timescale 1ns/1ps
module iee_dev
  import iee_pkg::*;
#(
  parameter int unsigned WR_CYC = IEE_WR_CYC
) (
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RSTN_IN,
  iee_if.dev              BUS,
  input  wire logic       WP_IN,
  input  wire logic [2:0] DEV_SEL_IN,
  output logic            BUSY_OUT
);
  // ==========================================================
  // Declarations
  logic [2:0]                   scl_ff;
  logic [2:0]                   sda_ff;
  logic [1:0]                   wp_ff;
  logic [2:0]                   sel_m_ff;
  logic [2:0]                   sel_s_ff;
  iee_dstate_t                  state_ff;
  logic [3:0]                   bit_ff;
  logic [7:0]                   sh_ff;
  logic [7:0]                   rd_ff;
  logic                         ack_ff;
  logic                         first_rd_ff;
  logic                         got_ff;
  logic                         arm_ff;
  logic                         oe_n_ff;
  logic [IEE_ADDR_W-1:0]        addr_ff;
  logic [IEE_ADDR_W-IEE_PB-1:0] page_ff;
  logic [IEE_PAGE_N-1:0]        mask_ff;
  logic [31:0]                  prog_ff;
  logic [7:0]                   mem  [IEE_MEM_N];
  logic [7:0]                   pbuf [IEE_PAGE_N];
  logic                         scl_s;
  logic                         sda_s;
  logic                         wp_s;
  logic                         rise;
  logic                         fall;
  logic                         start;
  logic                         stop;
  logic                         prog_done;
  logic                         wp_cancel;
  logic                         data_stb;
  logic [7:0]                   nb;

  // ==========================================================
  // Helpers
  function automatic logic [IEE_ADDR_W-1:0] page_inc(input logic [IEE_ADDR_W-1:0] a);
    return {a[IEE_ADDR_W-1:IEE_PB], a[IEE_PB-1:0] + 1'b1};
  endfunction

  function automatic logic sel_match(input logic [7:0] b, input logic [2:0] s);
    return (b[7:4] == IEE_DEV_CODE) && (IEE_SMALL || (b[3:1] == s));
  endfunction

  // ==========================================================
  // Pin synchronisers and bus events
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      scl_ff   <= 3'h7;
      sda_ff   <= 3'h7;
      wp_ff    <= 2'h0;
      sel_m_ff <= 3'h0;
      sel_s_ff <= 3'h0;
    end else begin
      scl_ff   <= {scl_ff[1:0], BUS.scl};
      sda_ff   <= {sda_ff[1:0], BUS.sda};
      wp_ff    <= {wp_ff[0], WP_IN};
      sel_m_ff <= DEV_SEL_IN;
      sel_s_ff <= sel_m_ff;
    end
  end

  assign scl_s     = scl_ff[1];
  assign sda_s     = sda_ff[1];
  assign wp_s      = wp_ff[1];
  assign rise      = scl_s && !scl_ff[2];
  assign fall      = !scl_s && scl_ff[2];
  assign start     = scl_s && scl_ff[2] && sda_ff[2] && !sda_s;
  assign stop      = scl_s && scl_ff[2] && !sda_ff[2] && sda_s;
  assign prog_done = (prog_ff == 32'(WR_CYC - 1));
  assign nb        = {sh_ff[6:0], sda_s};
  assign wp_cancel = (state_ff == ST_WDATA) && arm_ff && wp_s;
  assign data_stb  = rise && (state_ff == ST_WDATA) && (bit_ff == 4'h7) && !wp_cancel;

  // ==========================================================
  // Command sequencer
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_ff    <= ST_IDLE;
      bit_ff      <= 4'h0;
      sh_ff       <= 8'h00;
      rd_ff       <= 8'hFF;
      ack_ff      <= 1'b0;
      first_rd_ff <= 1'b0;
      got_ff      <= 1'b0;
      arm_ff      <= 1'b0;
      addr_ff     <= '0;
    end else if (state_ff == ST_BUSY) begin
      // Bus ignored, no acknowledge while programming
      if (wp_s || prog_done) begin
        state_ff <= ST_IDLE;
      end
    end else if (start) begin
      state_ff    <= ST_DEVSEL;
      bit_ff      <= 4'h0;
      ack_ff      <= 1'b0;
      first_rd_ff <= 1'b0;
      got_ff      <= 1'b0;
      arm_ff      <= 1'b0;
    end else if (stop) begin
      // The stop's own SCL rise counted one extra bit
      if ((state_ff == ST_WDATA) && got_ff && (bit_ff == 4'h1) && !wp_s) begin
        state_ff <= ST_BUSY;
      end else begin
        state_ff <= ST_IDLE;
      end
      bit_ff      <= 4'h0;
      ack_ff      <= 1'b0;
      first_rd_ff <= 1'b0;
      got_ff      <= 1'b0;
      arm_ff      <= 1'b0;
    end else if (wp_cancel) begin
      state_ff <= ST_WAIT;
      got_ff   <= 1'b0;
    end else if (rise && (state_ff != ST_IDLE) && (state_ff != ST_WAIT)) begin
      if (bit_ff == 4'h8) begin
        bit_ff <= 4'h0;
        ack_ff <= 1'b0;
        if (first_rd_ff || ((state_ff == ST_RDATA) && !sda_s)) begin
          rd_ff       <= mem[addr_ff];
          addr_ff     <= addr_ff + 1'b1;
          first_rd_ff <= 1'b0;
        end else if (state_ff == ST_RDATA) begin
          state_ff <= ST_WAIT;
        end
      end else begin
        sh_ff  <= nb;
        bit_ff <= bit_ff + 4'h1;
        if (bit_ff == 4'h7) begin
          case (state_ff)
            ST_DEVSEL: begin
              if (sel_match(nb, sel_s_ff)) begin
                ack_ff <= 1'b1;
                if (nb[0]) begin
                  first_rd_ff <= 1'b1;
                  state_ff    <= ST_RDATA;
                end else if (IEE_SMALL) begin
                  addr_ff  <= IEE_ADDR_W'({nb[3:1], addr_ff[7:0]});
                  state_ff <= ST_WA_LO;
                end else begin
                  state_ff <= ST_WA_HI;
                end
              end else begin
                state_ff <= ST_WAIT;
              end
            end
            ST_WA_HI: begin
              ack_ff   <= 1'b1;
              addr_ff  <= IEE_ADDR_W'({nb, addr_ff[7:0]});
              state_ff <= ST_WA_LO;
            end
            ST_WA_LO: begin
              ack_ff       <= 1'b1;
              addr_ff[7:0] <= nb;
              state_ff     <= ST_WDATA;
            end
            ST_WDATA: begin
              ack_ff  <= 1'b1;
              got_ff  <= 1'b1;
              arm_ff  <= 1'b1;
              addr_ff <= page_inc(addr_ff);
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // SDA driver, changes only after SCL falls
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      oe_n_ff <= 1'b1;
    end else if (state_ff inside {ST_IDLE, ST_WAIT, ST_BUSY} || start || stop) begin
      oe_n_ff <= 1'b1;
    end else if (fall) begin
      if (bit_ff == 4'h8) begin
        oe_n_ff <= !ack_ff;
      end else if ((state_ff == ST_RDATA) && !first_rd_ff) begin
        oe_n_ff <= rd_ff[3'(4'h7 - bit_ff)];
      end else begin
        oe_n_ff <= 1'b1;
      end
    end
  end

  assign BUS.dev_sda_oe_n = oe_n_ff;
  assign BUS.dev_sda_out  = 1'b0;

  // ==========================================================
  // Page buffer bookkeeping and write timer
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      mask_ff <= '0;
      page_ff <= '0;
    end else if (start && (state_ff != ST_BUSY)) begin
      mask_ff <= '0;
    end else if (data_stb) begin
      mask_ff[addr_ff[IEE_PB-1:0]] <= 1'b1;
      page_ff                      <= addr_ff[IEE_ADDR_W-1:IEE_PB];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      prog_ff  <= 32'h0;
      BUSY_OUT <= 1'b0;
    end else begin
      prog_ff  <= (state_ff == ST_BUSY) ? prog_ff + 32'h1 : 32'h0;
      BUSY_OUT <= (state_ff == ST_BUSY);
    end
  end

  // ==========================================================
  // Storage: loaded page bytes programmed at the end of the write time
  always_ff @(posedge SYS_CLK_IN) begin
    if (data_stb) begin
      pbuf[addr_ff[IEE_PB-1:0]] <= nb;
    end
    if ((state_ff == ST_BUSY) && prog_done && !wp_s) begin
      for (int i = 0; i < IEE_PAGE_N; i++) begin
        if (mask_ff[i]) begin
          mem[{page_ff, IEE_PB'(i)}] <= pbuf[i];
        end
      end
    end
  end
endmodule

// file: iee_sva.sv
// Checker of the two-wire link and the engine's busy flag.
// Assumes the bench wires it beside the interface that joins both ends.
`timescale 1ns/1ps
module iee_sva #(
  parameter int unsigned WR_CYC = 500000
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic BUSY_OUT,
  input wire logic WP_IN
);
  int unsigned busy_cnt_ff;
  int unsigned stop_age_ff;
  int unsigned drv_cnt_ff;
  logic        sda_q_ff;
  logic        wp_seen_ff;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // ==========================================
  // Helper counters
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) busy_cnt_ff <= 0;
    else busy_cnt_ff <= BUSY_OUT ? busy_cnt_ff + 1 : 0;
  end
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) sda_q_ff <= 1'b1;
    else sda_q_ff <= sda;
  end
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) stop_age_ff <= 1000;
    else if (scl && sda && !sda_q_ff) stop_age_ff <= 0;
    else if (stop_age_ff < 1000) stop_age_ff <= stop_age_ff + 1;
  end
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) wp_seen_ff <= 1'b0;
    else if (!BUSY_OUT) wp_seen_ff <= 1'b0;
    else if (WP_IN) wp_seen_ff <= 1'b1;
  end
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) drv_cnt_ff <= 0;
    else drv_cnt_ff <= dev_sda_oe_n ? 0 : drv_cnt_ff + 1;
  end
  // ==========================================
  // Assertions
  a_busy_no_ack: assert property (BUSY_OUT |-> dev_sda_oe_n)
    else $error("device drove SDA while busy");
  a_drive_low_only: assert property (!dev_sda_oe_n |-> !dev_sda_out)
    else $error("device drove SDA high");
  a_busy_max_len: assert property (BUSY_OUT |-> busy_cnt_ff <= WR_CYC + 2)
    else $error("busy longer than write time");
  a_busy_full_len: assert property ($fell(BUSY_OUT) && !wp_seen_ff |-> busy_cnt_ff + 2 >= WR_CYC)
    else $error("write time ended early");
  a_wp_abort_now: assert property (BUSY_OUT && WP_IN |-> ##[1:8] !BUSY_OUT)
    else $error("protect did not abort write");
  a_prog_on_stop: assert property ($rose(BUSY_OUT) |-> stop_age_ff <= 12)
    else $error("programming began without stop");
  a_sda_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl, 2))
    else $error("device changed SDA with SCL high");
  a_drive_bounded: assert property (drv_cnt_ff <= 2300)
    else $error("device held SDA low too long");
  c_prog: cover property ($rose(BUSY_OUT));
  c_abort: cover property ($fell(BUSY_OUT) && wp_seen_ff);
  c_ack: cover property (!dev_sda_oe_n && scl);
endmodule

// file: tb_i2c_eeprom_command_engine.sv
// Bench: engine and master joined by the link, driven from the register port.
// Assumes the register map and command codes of the shared package.
`timescale 1ns/1ps
module tb_i2c_eeprom_command_engine
  import iee_pkg::*;
;
  localparam int          WR = 3000;
  localparam logic [15:0] AD = 16'h0123;
  logic        clk;
  logic        rst_n;
  logic        wp;
  logic        busy;
  logic        reg_wr;
  logic        reg_rd;
  logic [2:0]  dsel;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] rdata;
  logic [15:0] st;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          hits = 0;
  int          h;
  int          n;
  iee_if bus ();
  iee_dev #(.WR_CYC(WR)) i_iee_dev (.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .BUS(bus),
    .WP_IN(wp), .DEV_SEL_IN(dsel), .BUSY_OUT(busy));
  iee_host i_iee_host (.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .BUS(bus), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata));
  iee_sva #(.WR_CYC(WR)) i_iee_sva (.SYS_CLK_IN(clk), .RSTN_IN(rst_n), .scl(bus.scl),
    .sda(bus.sda), .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .BUSY_OUT(busy), .WP_IN(wp));
  // ==========================================
  // Clock, watchdog, busy monitor
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) hits <= hits + 1;
    if (cyc == 95000) begin
      fail_count++;
      test_done();
    end
  end
  // ==========================================
  // Tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    st = rdata;
  endtask
  task automatic cmd(input iee_cmd_t c);
    int k;
    wr(IEE_REG_CMD, {13'h0, c});
    k = 0;
    rd(IEE_REG_STAT);
    while (st[IEE_STAT_BUSY] !== 1'b0 && k < 20000) begin
      rd(IEE_REG_STAT);
      k++;
    end
    if (k == 20000) fail_count++;
  endtask
  task automatic xfer(input iee_cmd_t c, input logic [15:0] a, input logic [15:0] d);
    wr(IEE_REG_ADDR, a);
    wr(IEE_REG_DATA, d);
    cmd(c);
  endtask
  task automatic stat_bit(input int b, input logic e);
    rd(IEE_REG_STAT);
    chk({15'h0, st[b]}, {15'h0, e});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    dsel = 3'h5;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wr(IEE_REG_SEL, 16'h0005);
    xfer(IEE_C_WRITE, AD, 16'h005A);
    stat_bit(IEE_STAT_NACK, 1'b0);
    cmd(IEE_C_POLL);
    stat_bit(IEE_STAT_NACK, 1'b1);
    for (n = 0; n < WR && busy !== 1'b0; n++) @(posedge clk);
    cmd(IEE_C_POLL);
    stat_bit(IEE_STAT_NACK, 1'b0);
    xfer(IEE_C_WRITE, AD - 16'h0001, 16'h00C3);
    for (n = 0; n < WR && busy !== 1'b0; n++) @(posedge clk);
    h = hits;
    wp <= 1'b1;
    xfer(IEE_C_WRITE, AD, 16'h00A5);
    repeat (20) @(posedge clk);
    chk(16'(hits - h), 16'h0000);
    stat_bit(IEE_STAT_NACK, 1'b1);
    wp <= 1'b0;
    xfer(IEE_C_RREAD, AD - 16'h0001, 16'h0000);
    rd(IEE_REG_DATA);
    chk({8'h00, st[7:0]}, 16'h00C3);
    xfer(IEE_C_CREAD, 16'h0000, 16'h0000);
    rd(IEE_REG_DATA);
    chk({8'h00, st[7:0]}, 16'h005A);
    wr(IEE_REG_SEL, 16'h0002);
    cmd(IEE_C_POLL);
    stat_bit(IEE_STAT_NACK, 1'b1);
    wr(IEE_REG_SEL, 16'h0005);
    cmd(IEE_C_CANCEL);
    stat_bit(IEE_STAT_UNK, 1'b1);
    cmd(IEE_C_SRST);
    xfer(IEE_C_RREAD, AD, 16'h0000);
    rd(IEE_REG_DATA);
    chk({8'h00, st[7:0]}, 16'h005A);
    xfer(IEE_C_WRITE, AD, 16'h003C);
    for (n = 0; n < 100 && busy !== 1'b1; n++) @(posedge clk);
    chk({15'h0, busy}, 16'h0001);
    wp <= 1'b1;
    repeat (12) @(posedge clk);
    chk({15'h0, busy}, 16'h0000);
    wp <= 1'b0;
    cmd(IEE_C_POLL);
    stat_bit(IEE_STAT_NACK, 1'b0);
    test_done();
  end
endmodule
